// *** rtl/random_number_request_port.sv ***
`timescale 1ns/1ps
// How it works
// - Each random instruction delivers a 64-bit value to its destination.
// - Requests go out only as one uncached strongly ordered paired load.
// - Address is base[47:16], core id[10:0], type bit, four zero bits.
// - Address bit 4 is 0 for a plain read and 1 for a reseeded read.
// - A bus error fails the request, sets zero flag, raises system error.
// - Both registers are 64 bits wide and clear to zero on reset.
module random_number_request_port
   import rnrp_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk,
   input  wire logic               rst,
   // System register access
   input  wire logic               regWrEn,
   input  wire logic               regWrSel,
   input  wire logic [REG_W-1:0]   regWrData,
   output logic      [REG_W-1:0]   pageBaseRd,
   output logic      [REG_W-1:0]   reqIdRd,
   // Instruction side
   input  wire logic               instReq,
   input  wire logic               instReseed,
   output logic                    instBusy,
   output logic                    instDone,
   output logic      [REG_W-1:0]   instResult,
   output logic                    zeroFlag,
   output logic                    sysErrIrq,
   // Device read request
   output logic                    rdValid,
   output logic      [ADDR_W-1:0]  rdAddr,
   output logic                    rdDevice,
   input  wire logic               rdReady,
   // Device read response
   input  wire logic               rspValid,
   input  wire logic [RESP_W-1:0]  rspData,
   input  wire logic               rspErr
);
   logic [REG_W-1:0]  pageBase;
   logic [REG_W-1:0]  reqId;
   rnrp_state_e       state_ff;
   logic              busy_ff;
   logic              rdValid_ff;
   logic [ADDR_W-1:0] rdAddr_ff;
   logic              done_ff;
   logic [REG_W-1:0]  result_ff;
   logic              zero_ff;
   logic              irq_ff;
   logic [REG_W-1:0]  pbRd_ff;
   logic [REG_W-1:0]  idRd_ff;

   // ----------------------------------------------------------------------
   // Register file
   // ----------------------------------------------------------------------
   rnrp_regs uRegs (
      .ref_clk     (ref_clk),
      .rst         (rst),
      .regWrEn     (regWrEn),
      .regWrSel    (regWrSel),
      .regWrData   (regWrData),
      .pageBase_ff (pageBase),
      .reqId_ff    (reqId)
   );

   // Read-back copies keep the outputs straight from flip-flops.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pbRd_ff <= PAGE_BASE_RST;
         idRd_ff <= REQ_ID_RST;
      end else begin
         pbRd_ff <= pageBase;
         idRd_ff <= reqId;
      end
   end

   // ----------------------------------------------------------------------
   // Request sequencer
   // ----------------------------------------------------------------------
   // Accepts one instruction at a time and waits for its answer.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         state_ff <= RNRP_IDLE;
      end else begin
         case (state_ff)
            RNRP_IDLE: begin
               if (instReq) begin
                  state_ff <= RNRP_WAIT;
               end
            end
            RNRP_WAIT: begin
               if (rspValid) begin
                  state_ff <= RNRP_DONE;
               end
            end
            RNRP_DONE: state_ff <= RNRP_IDLE;
            default:   state_ff <= RNRP_IDLE;
         endcase
      end
   end

   // Busy flag tracks the sequencer so the output comes from a flop.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         busy_ff <= 1'h0;
      end else if (state_ff == RNRP_IDLE && instReq) begin
         busy_ff <= 1'h1;
      end else if (state_ff == RNRP_DONE) begin
         busy_ff <= 1'h0;
      end
   end

   // Drives the single device read until the fabric takes it.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         rdValid_ff <= 1'h0;
         rdAddr_ff  <= '0;
      end else if (state_ff == RNRP_IDLE && instReq) begin
         rdValid_ff <= 1'h1;
         rdAddr_ff  <= rnrp_addr(pageBase, reqId,
                                 instReseed ? TYPE_RESEED : TYPE_PLAIN);
      end else if (rdValid_ff && rdReady) begin
         rdValid_ff <= 1'h0;
      end
   end

   // ----------------------------------------------------------------------
   // Response handling
   // ----------------------------------------------------------------------
   // Destination write is held until the answer arrives.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         done_ff   <= 1'h0;
         result_ff <= '0;
         zero_ff   <= 1'h0;
         irq_ff    <= 1'h0;
      end else begin
         done_ff <= 1'h0;
         irq_ff  <= 1'h0;
         if (state_ff == RNRP_WAIT && rspValid) begin
            done_ff <= 1'h1;
            if (rspErr) begin
               result_ff <= '0;
               zero_ff   <= 1'h1;
               irq_ff    <= 1'h1;
            end else begin
               result_ff <= rspData[REG_W-1:0];
               zero_ff   <= (rspData[RESP_W-1:REG_W] == '0);
            end
         end
      end
   end

   // ----------------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------------
   assign pageBaseRd = pbRd_ff;
   assign reqIdRd    = idRd_ff;
   assign instBusy   = busy_ff;
   assign instDone   = done_ff;
   assign instResult = result_ff;
   assign zeroFlag   = zero_ff;
   assign sysErrIrq  = irq_ff;
   assign rdValid    = rdValid_ff;
   assign rdAddr     = rdAddr_ff;
   assign rdDevice   = rdValid_ff;

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_addr_format: assert property (@(posedge ref_clk) disable iff (rst)
      state_ff == RNRP_IDLE && instReq |=>
         rdAddr[ADDR_W-1:BASE_LO] == $past(pageBase[BASE_HI:BASE_LO]) &&
         rdAddr[15:5] == $past(reqId[CORE_ID_HI:0]) &&
         rdAddr[3:0] == 4'h0)
      else $error("request address malformed");
   chk_type_bit: assert property (@(posedge ref_clk) disable iff (rst)
      state_ff == RNRP_IDLE && instReq |=>
         rdAddr[TYPE_BIT] == $past(instReseed))
      else $error("request type bit wrong");
   chk_error_irq: assert property (@(posedge ref_clk) disable iff (rst)
      state_ff == RNRP_WAIT && rspValid && rspErr |=>
         sysErrIrq && zeroFlag && instDone)
      else $error("bus error not reported");
   chk_result_value: assert property (@(posedge ref_clk) disable iff (rst)
      state_ff == RNRP_WAIT && rspValid && !rspErr |=>
         instResult == $past(rspData[63:0]) && instDone)
      else $error("result not delivered");
   chk_zero_upper: assert property (@(posedge ref_clk) disable iff (rst)
      state_ff == RNRP_WAIT && rspValid && !rspErr |=>
         zeroFlag == ($past(rspData[127:64]) == 64'h0))
      else $error("zero flag wrong");
   chk_one_outstand: assert property (@(posedge ref_clk) disable iff (rst)
      rdValid && !rdReady |=> rdValid && $stable(rdAddr))
      else $error("request dropped or changed");
   chk_no_early: assert property (@(posedge ref_clk) disable iff (rst)
      instDone |-> $past(state_ff) == RNRP_WAIT && $past(rspValid))
      else $error("done without response");
   chk_uncached: assert property (@(posedge ref_clk) disable iff (rst)
      rdValid |-> rdDevice)
      else $error("request not device type");
   cov_plain: cover property (@(posedge ref_clk) instReq && !instReseed
      ##[1:20] instDone && !zeroFlag);
   cov_reseed: cover property (@(posedge ref_clk) instReq && instReseed
      ##[1:20] instDone);
   cov_error: cover property (@(posedge ref_clk) sysErrIrq);
   cov_timeout: cover property (@(posedge ref_clk)
      instDone && zeroFlag && !sysErrIrq);
   cov_refused: cover property (@(posedge ref_clk) instBusy && instReq);
   chk_no_reissue: assert property (@(posedge ref_clk) disable iff (rst)
      instBusy && instReq |=> $stable(rdAddr))
      else $error("request taken while busy");
   chk_err_result: assert property (@(posedge ref_clk) disable iff (rst)
      sysErrIrq |-> zeroFlag && instResult == 64'h0)
      else $error("failed request left a value");
endmodule : random_number_request_port

// *** pkg/rnrp_pkg.sv ***
package rnrp_pkg;
   // ----------------------------------------------------------------------
   // Widths and address layout
   // ----------------------------------------------------------------------
   localparam int REG_W       = 64;
   localparam int ADDR_W      = 48;
   localparam int RESP_W      = 128;
   localparam int BASE_HI     = 47;
   localparam int BASE_LO     = 16;
   localparam int CORE_ID_HI  = 10;
   localparam int TYPE_BIT    = 4;
   localparam int LOW_ZEROS   = 4;
   // ----------------------------------------------------------------------
   // Reset values and request types
   // ----------------------------------------------------------------------
   localparam logic [63:0] PAGE_BASE_RST = 64'h0;
   localparam logic [63:0] REQ_ID_RST    = 64'h0;
   localparam logic        TYPE_PLAIN    = 1'h0;
   localparam logic        TYPE_RESEED   = 1'h1;
   // Register selects on the system register write port.
   localparam logic        SEL_PAGE_BASE = 1'h0;
   localparam logic        SEL_REQ_ID    = 1'h1;

   typedef enum logic [1:0] {RNRP_IDLE, RNRP_WAIT, RNRP_DONE} rnrp_state_e;

   // Builds the request physical address from base, core id and type.
   function automatic logic [ADDR_W-1:0] rnrp_addr(
      input logic [63:0] base, input logic [63:0] id, input logic typ);
      rnrp_addr = {base[BASE_HI:BASE_LO], id[CORE_ID_HI:0], typ,
                   LOW_ZEROS'(0)};
   endfunction : rnrp_addr
endpackage : rnrp_pkg

// *** rtl/rnrp_regs.sv ***
`timescale 1ns/1ps
module rnrp_regs
   import rnrp_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // System register write port
   input  wire logic              regWrEn,
   input  wire logic              regWrSel,
   input  wire logic [REG_W-1:0]  regWrData,
   // Register contents
   output logic      [REG_W-1:0]  pageBase_ff,
   output logic      [REG_W-1:0]  reqId_ff
);
   // ----------------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------------
   // Page base register clears to zero on reset.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         pageBase_ff <= PAGE_BASE_RST;
      end else if (regWrEn && regWrSel == SEL_PAGE_BASE) begin
         pageBase_ff <= regWrData;
      end
   end

   // Requester id register clears to zero on reset.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         reqId_ff <= REQ_ID_RST;
      end else if (regWrEn && regWrSel == SEL_REQ_ID) begin
         reqId_ff <= regWrData;
      end
   end

   // ----------------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------------
   chk_base_write: assert property (@(posedge ref_clk) disable iff (rst)
      regWrEn && regWrSel == SEL_PAGE_BASE |=> pageBase_ff == $past(regWrData))
      else $error("page base not written");
endmodule : rnrp_regs

// *** testbench/rnrp_periph_model.sv ***
`timescale 1ns/1ps
// --------------------------------------------------------------------------
// Entropy peripheral on the far side of the device read port
// --------------------------------------------------------------------------
module rnrp_periph_model
   import rnrp_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk,
   input  wire logic              rst,
   // Read request
   input  wire logic              rdValid,
   input  wire logic [ADDR_W-1:0] rdAddr,
   input  wire logic              rdDevice,
   output logic                   rdReady,
   // Read response
   output logic                   rspValid,
   output logic      [RESP_W-1:0] rspData,
   output logic                   rspErr,
   // Bench control: 0 good, 1 timeout, 2 bus error
   input  wire logic [1:0]        mode,
   input  wire logic [1:0]        delay,
   input  wire logic [63:0]       rndVal,
   output logic                   gotReseed,
   output logic      [10:0]       gotCore
);
   logic [1:0] cnt;
   logic       busy;
   // Accepts one read, waits, answers; idle data toggles every cycle.
   always_ff @(posedge ref_clk or posedge rst) begin
      if (rst) begin
         {cnt, busy, rdReady, rspValid, rspErr, gotReseed} <= '0;
         gotCore <= '0;
         rspData <= '1;
      end else begin
         rdReady <= 1'h0;
         rspValid <= 1'h0;
         rspErr <= 1'h0;
         rspData <= ~rspData;
         cnt <= cnt + 2'h1;
         if (!busy && rdValid && rdDevice && !rdReady) begin
            if (cnt >= delay) begin
               rdReady <= 1'h1;
               busy <= 1'h1;
               cnt <= 2'h0;
               gotReseed <= rdAddr[4];
               gotCore <= rdAddr[15:5];
            end
         end else if (busy && cnt >= delay) begin
            busy <= 1'h0;
            rspValid <= 1'h1;
            rspErr <= (mode == 2'h2);
            if (mode == 2'h0) rspData <= {64'h1, rndVal};
            else if (mode == 2'h1) rspData <= '0;
         end else if (!busy) begin
            cnt <= 2'h0;
         end
      end
   end
endmodule : rnrp_periph_model

// *** testbench/random_number_request_port_tb.sv ***
`timescale 1ns/1ps
module random_number_request_port_tb
   import rnrp_pkg::*;
;
   logic ref_clk = 1'h0;
   logic rst, regWrEn, regWrSel, instReq, instReseed, instBusy, instDone;
   logic zeroFlag, sysErrIrq, rdValid, rdDevice, rdReady, rspValid, rspErr;
   logic gotReseed;
   logic [REG_W-1:0] regWrData, pageBaseRd, reqIdRd, instResult, rndVal;
   logic [REG_W-1:0] pageBase, reqId;
   logic [ADDR_W-1:0] rdAddr;
   logic [RESP_W-1:0] rspData;
   logic [10:0] gotCore;
   logic [1:0] mode, delay, md;
   int err_count = 0;
   int n_tests = 0;
   int seed = 32'h477360E0;
   bit hung = 1'h0;
   // Clock at 250 MHz.
   always #2 ref_clk = ~ref_clk;
   random_number_request_port uut (.ref_clk(ref_clk), .rst(rst),
      .regWrEn(regWrEn), .regWrSel(regWrSel), .regWrData(regWrData),
      .pageBaseRd(pageBaseRd), .reqIdRd(reqIdRd), .instReq(instReq),
      .instReseed(instReseed), .instBusy(instBusy), .instDone(instDone),
      .instResult(instResult), .zeroFlag(zeroFlag), .sysErrIrq(sysErrIrq),
      .rdValid(rdValid), .rdAddr(rdAddr), .rdDevice(rdDevice),
      .rdReady(rdReady), .rspValid(rspValid), .rspData(rspData),
      .rspErr(rspErr));
   rnrp_periph_model peer (.ref_clk(ref_clk), .rst(rst), .rdValid(rdValid),
      .rdAddr(rdAddr), .rdDevice(rdDevice), .rdReady(rdReady),
      .rspValid(rspValid), .rspData(rspData), .rspErr(rspErr), .mode(mode),
      .delay(delay), .rndVal(rndVal), .gotReseed(gotReseed),
      .gotCore(gotCore));
   // Counts a comparison and reports a mismatch.
   task automatic check(input string what, input logic [127:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %s exp %0h seen %0h", what, exp, seen);
      end
   endtask : check
   task automatic print_verdict;
      if (err_count == 0 && n_tests > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : print_verdict
   task automatic regWrite(input logic sel, input logic [63:0] d);
      @(negedge ref_clk);
      {regWrEn, regWrSel, regWrData} = {1'h1, sel, d};
      @(negedge ref_clk);
      regWrEn = 1'h0;
   endtask : regWrite
   // One instruction; the request is held high while busy to be refused.
   task automatic doRand(input logic rs);
      logic [ADDR_W-1:0] expAddr;
      int k;
      expAddr = {pageBase[47:16], reqId[10:0], rs, 4'h0};
      @(negedge ref_clk);
      {instReq, instReseed, mode} = {1'h1, rs, md};
      delay = 2'($random(seed));
      rndVal = {$random(seed), $random(seed)};
      for (k = 0; k < 100 && instDone !== 1'h1; k++) begin
         @(negedge ref_clk);
         check("busy", instBusy, 1'h1);
         check("rdDevice", rdDevice, rdValid);
         if (rdValid === 1'h1) check("rdAddr", rdAddr, expAddr);
      end
      instReq = 1'h0;
      if (k == 100) begin
         err_count++;
         hung = 1'h1;
      end
      check("result", instResult, md == 2'h0 ? rndVal : 64'h0);
      check("zero", zeroFlag, md != 2'h0);
      check("sysErr", sysErrIrq, md == 2'h2);
      check("seenType", gotReseed, rs);
      check("seenCore", gotCore, reqId[10:0]);
      repeat (2) @(negedge ref_clk);
      check("idleBusy", instBusy, 1'h0);
      check("noExtraRead", rdValid, 1'h0);
      check("resultHold", instResult, md == 2'h0 ? rndVal : 64'h0);
      check("donePulse", instDone, 1'h0);
      check("irqPulse", sysErrIrq, 1'h0);
   endtask : doRand
   // Reset, register checks, then mixed random and corner requests.
   initial begin
      {rst, regWrEn, regWrSel, instReq, instReseed, mode, delay} = 9'h100;
      {regWrData, rndVal, md} = '0;
      repeat (6) @(posedge ref_clk);
      @(negedge ref_clk) rst = 1'h0;
      check("baseRst", pageBaseRd, 64'h0);
      check("idRst", reqIdRd, 64'h0);
      check("zeroRst", zeroFlag, 1'h0);
      check("busyRst", instBusy, 1'h0);
      check("readRst", rdValid, 1'h0);
      for (int i = 0; i < 24 && !hung; i++) begin
         if (i % 4 == 0) begin
            pageBase = i == 0 ? '1 : {$random(seed), $random(seed)};
            reqId = i == 0 ? '1 : {$random(seed), $random(seed)};
            regWrite(SEL_PAGE_BASE, pageBase);
            regWrite(SEL_REQ_ID, reqId);
            repeat (2) @(negedge ref_clk);
            check("baseRd", pageBaseRd, pageBase);
            check("idRd", reqIdRd, reqId);
         end
         md = i < 3 ? 2'(i) : 2'($unsigned($random(seed)) % 3);
         doRand(i < 2 ? i[0] : 1'($random(seed)));
      end
      // Reset in mid-request clears the port and both registers.
      if (!hung) begin
         @(negedge ref_clk) instReq = 1'h1;
         @(negedge ref_clk) {rst, instReq} = 2'h2;
         repeat (2) @(negedge ref_clk);
         rst = 1'h0;
         check("midBusy", instBusy, 1'h0);
         check("midRead", rdValid, 1'h0);
         check("midBase", pageBaseRd, 64'h0);
         check("midId", reqIdRd, 64'h0);
         {pageBase, reqId, md} = '0;
         doRand(1'h1);
      end
      print_verdict();
   end
endmodule : random_number_request_port_tb
